/* File: rate_params.svh */
// constants of the bit-rate generator: register offsets, field positions,
// write masks, reset values and prescale terminal counts.
// assumes it is included by bare name wherever a constant is needed.
`ifndef RATE_PARAMS_SVH
`define RATE_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets on the 3-bit register port
// ----------------------------------------------------------------------------
`define REG_CTRL_FIRST 3'h0
`define REG_CTRL_SECOND 3'h1
`define REG_RX_CTRL 3'h2
`define REG_DIV_LOW 3'h3
`define REG_DIV_HIGH 3'h4
`define REG_TX_CTRL 3'h5

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTRL_IDLE_BIT 6
`define CTRL_WIDE_BIT 3
`define TX_SYNC_BIT 4
`define TX_HS_BIT 2
`define TX_EMPTY_BIT 1

// ----------------------------------------------------------------------------
// write masks and reset values
// ----------------------------------------------------------------------------
`define CTRL_WR_MASK 8'h1b
`define RX_WR_MASK 8'hf8
`define TX_WR_MASK 8'hfd
`define CTRL_RESET 8'h00
`define RX_RESET 8'h00
`define TX_RESET 8'h00
`define DIV_RESET 8'h00

// ----------------------------------------------------------------------------
// prescale terminal counts (multiplier minus one) and multiplier values
// ----------------------------------------------------------------------------
`define PRE_TERM_4 6'h03
`define PRE_TERM_16 6'h0f
`define PRE_TERM_64 6'h3f
`define MULT_VAL_4 23'h000004
`define MULT_VAL_16 23'h000010
`define MULT_VAL_64 23'h000040

`endif

/* File: rate_pkg.sv */
// types shared by the bit-rate generator modules.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package rate_pkg;
  typedef enum logic [1:0] {MULT_4, MULT_16, MULT_64} mult_e;
  typedef logic [15:0] divisor_t;
  typedef logic [7:0] byte_t;
endpackage : rate_pkg

`default_nettype wire

/* File: rate_link.sv */
// carrier between the top of the bit-rate generator and its two counters.
// assumes rate_pkg is compiled first.
`default_nettype none

interface rate_link;
  import rate_pkg::*;
  logic clear;
  mult_e mult;
  logic prescale_tick;
  logic [5:0] prescale_count;
  divisor_t divisor;
  logic wide;
  divisor_t timer_count;
  logic bit_tick;

  modport prescaler_side (input clear, input mult, output prescale_tick, output prescale_count);
  modport timer_side (input clear, input prescale_tick, input divisor, input wide,
                      output timer_count, output bit_tick);
  modport top_side (output clear, output mult, output divisor, output wide,
                    input prescale_tick, input prescale_count, input timer_count, input bit_tick);
endinterface : rate_link

`default_nettype wire

/* File: rate_prescaler.sv */
// prescaler of the bit-rate generator: one enable pulse every 4, 16 or 64
// core clocks, as the selected multiplier asks.
// assumes clear and mult come from logic on the same clock.
`default_nettype none
`include "rate_params.svh"

module rate_prescaler (
  input wire logic core_clk_in, // core clock
  input wire logic reset_n_in, // asynchronous reset, active low
  rate_link.prescaler_side link_port // controls in, enable pulse out
);
  import rate_pkg::*;

  logic [5:0] count;
  logic [5:0] term;
  logic at_term;

  assign term = (link_port.mult == MULT_4) ? `PRE_TERM_4 :
                (link_port.mult == MULT_16) ? `PRE_TERM_16 : `PRE_TERM_64;
  // >= so that a change to a smaller multiplier never strands the count
  assign at_term = (count >= term);
  assign link_port.prescale_tick = at_term & ~link_port.clear;
  assign link_port.prescale_count = count;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= 6'h00;
    end else if (link_port.clear || at_term) begin
      count <= 6'h00;
    end else begin
      count <= count + 6'h01;
    end
  end
endmodule : rate_prescaler

`default_nettype wire

/* File: rate_timer.sv */
// divisor timer of the bit-rate generator: counts prescale pulses from 0 to n
// and gives one bit-rate pulse per period.
// assumes its inputs come from logic on the same clock.
`default_nettype none
`include "rate_params.svh"

module rate_timer (
  input wire logic core_clk_in, // core clock
  input wire logic reset_n_in, // asynchronous reset, active low
  rate_link.timer_side link_port // divisor in, count and pulse out
);
  import rate_pkg::*;

  divisor_t count;
  divisor_t period;
  logic tick;
  logic at_period;

  assign period = link_port.wide ? link_port.divisor : {8'h00, link_port.divisor[7:0]};
  assign at_period = (count >= period);
  assign link_port.timer_count = count;
  assign link_port.bit_tick = tick;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= link_port.prescale_tick & at_period & ~link_port.clear;
      if (link_port.clear) begin
        count <= 16'h0000;
      end else if (link_port.prescale_tick) begin
        count <= at_period ? 16'h0000 : count + 16'h0001;
      end
    end
  end
endmodule : rate_timer

`default_nettype wire

/* File: rate_generator.sv */
// top of the bit-rate generator of the serial port: register file, mode
// decode, the two counters and the checks that guard them.
// assumes a same-clock register master and a same-clock receiver that
// reports when it is busy; transmitter and receiver sit outside.
//
// Function
// - timer starts 8-bit after reset, 16-bit once wide select is set
// - period is n from divisor high over low byte when 16-bit, low byte alone when 8-bit, repeating freely
// - async multiplier chosen by high-speed and wide select together
// - sync mode ignores high-speed, divides by 4 times (n+1) any width
// - async 8-bit, high-speed clear divides by 64 times (n+1)
// - async 16-bit, high-speed clear divides by 16 times (n+1)
// - any divisor byte write clears the timer, new rate at once
// - one shared generator times both async and sync operation
// - idle flag reads one when receiver idle, zero while receiving in async mode; always one in sync mode
//
// Local design decisions: strobed register access and the placing of the registers.
`default_nettype none
`include "rate_params.svh"

module rate_generator (
  input wire logic core_clk_in, // 20 MHz core clock
  input wire logic reset_n_in, // asynchronous reset, active low
  input wire logic [2:0] reg_addr_in, // register offset
  input wire rate_pkg::byte_t reg_wdata_in, // write data
  input wire logic reg_write_in, // write strobe, one cycle
  input wire logic reg_read_in, // read strobe, one cycle
  output var rate_pkg::byte_t reg_rdata_out, // read data, cycle after strobe
  input wire logic receive_active_in, // receiver busy with a character
  input wire logic tx_shift_empty_in, // transmit shifter empty
  output logic bit_tick_out, // one pulse per bit period
  output logic sync_mode_out, // synchronous mode selected
  output rate_pkg::divisor_t timer_count_out // live timer count
);
  import rate_pkg::*;

  // --------------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------------
  byte_t ctrl_first;
  byte_t ctrl_second;
  byte_t rx_ctrl;
  byte_t div_low;
  byte_t div_high;
  byte_t tx_ctrl;
  byte_t read_mux;

  rate_link link ();

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  wire wr_ctrl_first = reg_write_in && (reg_addr_in == `REG_CTRL_FIRST);
  wire wr_ctrl_second = reg_write_in && (reg_addr_in == `REG_CTRL_SECOND);
  wire wr_rx_ctrl = reg_write_in && (reg_addr_in == `REG_RX_CTRL);
  wire wr_div_low = reg_write_in && (reg_addr_in == `REG_DIV_LOW);
  wire wr_div_high = reg_write_in && (reg_addr_in == `REG_DIV_HIGH);
  wire wr_tx_ctrl = reg_write_in && (reg_addr_in == `REG_TX_CTRL);
  wire div_write = wr_div_low || wr_div_high;

  // --------------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------------
  wire wide_sel = ctrl_first[`CTRL_WIDE_BIT];
  wire high_speed_sel = tx_ctrl[`TX_HS_BIT];
  wire sync_sel = tx_ctrl[`TX_SYNC_BIT];
  // high-speed only matters when async, so sync wins first
  wire pick_4 = sync_sel || (wide_sel && high_speed_sel);
  wire pick_64 = !sync_sel && !wide_sel && !high_speed_sel;
  wire mult_e mult_sel = pick_4 ? MULT_4 : (pick_64 ? MULT_64 : MULT_16);
  // the idle flag has no meaning in sync mode and reads as idle there
  wire idle_flag = sync_sel || !receive_active_in;
  wire divisor_t eff_period = wide_sel ? {div_high, div_low} : {8'h00, div_low};

  assign link.clear = div_write;
  assign link.mult = mult_sel;
  assign link.divisor = {div_high, div_low};
  assign link.wide = wide_sel;

  // --------------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_first <= `CTRL_RESET;
      ctrl_second <= `CTRL_RESET;
      rx_ctrl <= `RX_RESET;
      tx_ctrl <= `TX_RESET;
    end else begin
      if (wr_ctrl_first) begin
        ctrl_first <= reg_wdata_in & `CTRL_WR_MASK;
      end
      if (wr_ctrl_second) begin
        ctrl_second <= reg_wdata_in & `CTRL_WR_MASK;
      end
      if (wr_rx_ctrl) begin
        rx_ctrl <= reg_wdata_in & `RX_WR_MASK;
      end
      if (wr_tx_ctrl) begin
        tx_ctrl <= reg_wdata_in & `TX_WR_MASK;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_low <= `DIV_RESET;
      div_high <= `DIV_RESET;
    end else begin
      if (wr_div_low) begin
        div_low <= reg_wdata_in;
      end
      if (wr_div_high) begin
        div_high <= reg_wdata_in;
      end
    end
  end

  // --------------------------------------------------------------------------
  // counters: one generator serves both modes, so a mode change never
  // restarts it; only a divisor write does
  // --------------------------------------------------------------------------
  rate_prescaler u_prescaler (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .link_port(link.prescaler_side)
  );

  rate_timer u_timer (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .link_port(link.timer_side)
  );

  assign bit_tick_out = link.bit_tick;
  assign sync_mode_out = sync_sel;
  assign timer_count_out = link.timer_count;

  // --------------------------------------------------------------------------
  // read back
  // --------------------------------------------------------------------------
  wire byte_t ctrl_first_rd = ctrl_first | {1'b0, idle_flag, 6'h00};
  wire byte_t tx_ctrl_rd = tx_ctrl | {6'h00, tx_shift_empty_in, 1'b0};

  always_comb begin
    unique case (reg_addr_in)
      `REG_CTRL_FIRST: read_mux = ctrl_first_rd;
      `REG_CTRL_SECOND: read_mux = ctrl_second;
      `REG_RX_CTRL: read_mux = rx_ctrl;
      `REG_DIV_LOW: read_mux = div_low;
      `REG_DIV_HIGH: read_mux = div_high;
      `REG_TX_CTRL: read_mux = tx_ctrl_rd;
      default: read_mux = 8'h00;
    endcase
  end

  // data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= reg_read_in ? read_mux : 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // checking helpers
  // --------------------------------------------------------------------------
  logic [22:0] gap_count;
  logic cfg_dirty;
  wire cfg_write = wr_ctrl_first || wr_tx_ctrl || div_write;
  wire [22:0] mult_value = pick_4 ? `MULT_VAL_4 : (pick_64 ? `MULT_VAL_64 : `MULT_VAL_16);
  wire [22:0] expected_gap = mult_value * ({7'h00, eff_period} + 23'h000001);

  // gap since the previous pulse; dirty marks a period disturbed by a write
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gap_count <= 23'h000001;
      cfg_dirty <= 1'b1;
    end else begin
      gap_count <= link.bit_tick ? 23'h000001 : gap_count + 23'h000001;
      if (cfg_write) begin
        cfg_dirty <= 1'b1;
      end else if (link.bit_tick) begin
        cfg_dirty <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence div_write_seq;
    div_write;
  endsequence

  sequence timer_restarted;
    link.timer_count == 16'h0000 && link.prescale_count == 6'h00 && !link.bit_tick;
  endsequence

  a_wide_select_write: assert property (
    wr_ctrl_first |=> link.wide == $past(reg_wdata_in[`CTRL_WIDE_BIT]))
    else $error("width select does not follow the control write");

  a_bit_gap_exact: assert property (
    link.bit_tick && !cfg_dirty |-> gap_count == expected_gap)
    else $error("bit period differs from multiplier times n plus one");

  a_async_joint_mult: assert property (
    (!sync_sel && link.prescale_tick && !cfg_dirty) |->
      link.prescale_count == ((wide_sel == high_speed_sel) ?
        (wide_sel ? `PRE_TERM_4 : `PRE_TERM_64) : `PRE_TERM_16))
    else $error("async multiplier does not follow both select bits");

  a_sync_ignores_hs: assert property (
    (sync_sel && link.prescale_tick && !cfg_dirty) |-> link.prescale_count == `PRE_TERM_4)
    else $error("sync mode prescale is not four");

  a_async_slow_eight: assert property (
    (!sync_sel && !wide_sel && !high_speed_sel && link.prescale_tick && !cfg_dirty)
      |-> link.prescale_count == `PRE_TERM_64)
    else $error("async 8-bit low speed prescale is not sixty-four");

  a_async_slow_wide: assert property (
    (!sync_sel && wide_sel && !high_speed_sel && link.prescale_tick && !cfg_dirty)
      |-> link.prescale_count == `PRE_TERM_16)
    else $error("async 16-bit low speed prescale is not sixteen");

  a_divisor_clears: assert property (
    div_write_seq |=> timer_restarted)
    else $error("divisor write did not restart the timer");

  a_mode_keeps_timer: assert property (
    (wr_tx_ctrl && !div_write) |=>
      (link.timer_count == $past(link.timer_count) ||
       link.timer_count == $past(link.timer_count) + 16'h0001 ||
       link.timer_count == 16'h0000))
    else $error("mode write disturbed the shared timer");

  a_idle_flag_read: assert property (
    (reg_read_in && reg_addr_in == `REG_CTRL_FIRST && !sync_sel) |=>
      reg_rdata_out[`CTRL_IDLE_BIT] == !$past(receive_active_in))
    else $error("idle flag does not show the receiver state");

  a_async_fast_eight: assert property (
    (!sync_sel && !wide_sel && high_speed_sel && link.prescale_tick && !cfg_dirty)
      |-> link.prescale_count == `PRE_TERM_16)
    else $error("async 8-bit high speed prescale is not sixteen");

  a_async_fast_wide: assert property (
    (!sync_sel && wide_sel && high_speed_sel && link.prescale_tick && !cfg_dirty)
      |-> link.prescale_count == `PRE_TERM_4)
    else $error("async 16-bit high speed prescale is not four");

  a_narrow_low_only: assert property (
    (link.bit_tick && !wide_sel && !cfg_dirty) |-> $past(link.timer_count) == {8'h00, div_low})
    else $error("8-bit period is not set by the low byte alone");

  a_read_one_cycle: assert property (
    !reg_read_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside the cycle after a read");

  // --------------------------------------------------------------------------
  // checks on the register port, the counter ranges and the pulse shapes
  // --------------------------------------------------------------------------
  sequence quiet_after_clear;
    (!link.bit_tick) [*3];
  endsequence

  sequence prescale_gap;
    (!link.prescale_tick) [*3];
  endsequence

  a_tick_single_pulse: assert property (
    link.bit_tick |=> !link.bit_tick)
    else $error("bit pulse lasts more than one cycle");

  a_quiet_after_clear: assert property (
    div_write_seq |=> quiet_after_clear)
    else $error("bit pulse too soon after a divisor write");

  a_prescale_spacing: assert property (
    link.prescale_tick |=> prescale_gap)
    else $error("prescale pulses closer than four cycles");

  a_timer_in_range: assert property (
    !cfg_dirty |-> link.timer_count <= eff_period)
    else $error("timer count ran past the period");

  a_prescale_in_range: assert property (
    !cfg_dirty |-> {17'h00000, link.prescale_count} < mult_value)
    else $error("prescale count ran past the multiplier");

  a_sync_out_follows: assert property (
    wr_tx_ctrl |=> sync_mode_out == $past(reg_wdata_in[`TX_SYNC_BIT]))
    else $error("sync output does not follow the control write");

  a_div_low_lands: assert property (
    wr_div_low |=> div_low == $past(reg_wdata_in))
    else $error("low divisor byte write did not land");

  a_div_high_lands: assert property (
    wr_div_high |=> div_high == $past(reg_wdata_in))
    else $error("high divisor byte write did not land");

  a_div_low_read: assert property (
    (reg_read_in && reg_addr_in == `REG_DIV_LOW) |=> reg_rdata_out == $past(div_low))
    else $error("low divisor byte reads back wrong");

  a_ctrl_mask_kept: assert property (
    wr_ctrl_first |=> (ctrl_first & ~`CTRL_WR_MASK) == 8'h00)
    else $error("read-only control bits took a write");

  a_rx_mask_kept: assert property (
    wr_rx_ctrl |=> (rx_ctrl & ~`RX_WR_MASK) == 8'h00)
    else $error("read-only receive bits took a write");

  a_tx_mask_kept: assert property (
    wr_tx_ctrl |=> (tx_ctrl & ~`TX_WR_MASK) == 8'h00)
    else $error("read-only transmit bits took a write");

  a_idle_in_sync: assert property (
    (reg_read_in && reg_addr_in == `REG_CTRL_FIRST && sync_sel) |=> reg_rdata_out[`CTRL_IDLE_BIT])
    else $error("idle flag does not read one in sync mode");

  a_tx_empty_read: assert property (
    (reg_read_in && reg_addr_in == `REG_TX_CTRL) |=>
      reg_rdata_out[`TX_EMPTY_BIT] == $past(tx_shift_empty_in))
    else $error("transmit empty bit does not show the shifter state");

  // unmapped offsets must never leak a stored byte
  a_unmapped_read_zero: assert property (
    (reg_read_in && reg_addr_in > `REG_TX_CTRL) |=> reg_rdata_out == 8'h00)
    else $error("unmapped offset does not read zero");

endmodule : rate_generator

`default_nettype wire

/* File: baud_rate_generator_bench.sv */
// self-checking bench of the bit-rate generator: register port, idle flag,
// multiplier table, divisor restart and free-running period.
// assumes rate_pkg, rate_link, rate_prescaler, rate_timer, rate_generator.
`default_nettype none
`include "rate_params.svh"

module baud_rate_generator_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rate_pkg::*;

  logic core_clk_in;
  logic reset_n_in;
  logic [2:0] reg_addr_in;
  byte_t reg_wdata_in;
  logic reg_write_in;
  logic reg_read_in;
  byte_t reg_rdata_out;
  logic receive_active_in;
  logic tx_shift_empty_in;
  logic bit_tick_out;
  logic sync_mode_out;
  divisor_t timer_count_out;

  int bad_count;
  int checks;
  byte_t rd_q[$];
  int per_q[$];
  byte_t sh[8];
  logic [15:0] lfsr;
  logic rd_prev;
  logic wr_prev;
  int cnt;
  int wcnt;
  int n_ticks;

  rate_generator dut (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .receive_active_in(receive_active_in),
    .tx_shift_empty_in(tx_shift_empty_in), .bit_tick_out(bit_tick_out),
    .sync_mode_out(sync_mode_out), .timer_count_out(timer_count_out)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic wrap_up;
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  function automatic logic [15:0] next_lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : next_lfsr

  function automatic byte_t rnd();
    lfsr = next_lfsr(lfsr);
    return lfsr[7:0];
  endfunction : rnd

  function automatic byte_t wmask(input logic [2:0] a);
    case (a)
      `REG_CTRL_FIRST, `REG_CTRL_SECOND: return `CTRL_WR_MASK;
      `REG_RX_CTRL: return `RX_WR_MASK;
      `REG_DIV_LOW, `REG_DIV_HIGH: return 8'hff;
      `REG_TX_CTRL: return `TX_WR_MASK;
      default: return 8'h00;
    endcase
  endfunction : wmask

  // idle reads one in sync mode, else the inverse of the busy input
  function automatic byte_t exp_rd(input logic [2:0] a);
    byte_t v;
    v = sh[a];
    if (a == `REG_CTRL_FIRST) v[`CTRL_IDLE_BIT] = sh[`REG_TX_CTRL][`TX_SYNC_BIT] | ~receive_active_in;
    if (a == `REG_TX_CTRL) v[`TX_EMPTY_BIT] = tx_shift_empty_in;
    return v;
  endfunction : exp_rd

  task automatic cmp_byte(input string name, input byte_t e, input byte_t g);
    checks++;
    if (e !== g) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask : cmp_byte

  task automatic cmp_int(input string name, input int e, input int g);
    checks++;
    if (e != g) begin
      bad_count++;
      $display("BAD %s expected %0d seen %0d", name, e, g);
    end
  endtask : cmp_int

  task automatic wr(input logic [2:0] a, input byte_t d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
    sh[a] = d & wmask(a);
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    rd_q.push_back(exp_rd(a));
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
  endtask : rd

  // ----------------------------------------------------------------------------
  // monitor: read data, restart of the count, tick spacing
  // ----------------------------------------------------------------------------
  always @(posedge core_clk_in) begin
    cnt++;
    wcnt++;
    if (rd_prev) begin
      if (rd_q.size() == 0) cmp_int("read queue", 0, 1);
      else cmp_byte("read data", rd_q.pop_front(), reg_rdata_out);
    end
    if (wr_prev) cmp_byte("count after divisor write", 8'h00, timer_count_out[7:0] | timer_count_out[15:8]);
    if (bit_tick_out === 1'b1) begin
      n_ticks++;
      if (per_q.size() > 0 && per_q[0] < 0 && wcnt >= 2) begin
        checks++;
        if (wcnt != -per_q[0] + 1 && wcnt != -per_q[0] + 2) begin
          bad_count++;
          $display("BAD first tick expected %0d seen %0d", -per_q[0] + 1, wcnt);
        end
        void'(per_q.pop_front());
      end else if (per_q.size() > 0 && per_q[0] > 0) begin
        cmp_int("tick period", per_q.pop_front(), cnt);
      end
      cnt = 0;
    end
    rd_prev = reg_read_in;
    wr_prev = reg_write_in && (reg_addr_in == `REG_DIV_LOW || reg_addr_in == `REG_DIV_HIGH);
    if (wr_prev) begin
      cnt = 0;
      wcnt = 0;
    end
  end

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    int m;
    int n;
    int p;
    int t;
    int k;
    byte_t lo;
    byte_t hi;
    logic [2:0] i;
    reset_n_in = 1'b0;
    reg_addr_in = 3'h0;
    reg_wdata_in = 8'h00;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    receive_active_in = 1'b0;
    tx_shift_empty_in = 1'b1;
    lfsr = 16'h1f0b;
    bad_count = 0;
    checks = 0;
    cnt = 0;
    wcnt = 0;
    n_ticks = 0;
    rd_prev = 1'b0;
    wr_prev = 1'b0;
    foreach (sh[j]) sh[j] = 8'h00;
    repeat (20) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[2:0]);
    // idle flag follows the busy input in async mode
    receive_active_in <= 1'b1;
    rd(`REG_CTRL_FIRST);
    receive_active_in <= 1'b0;
    tx_shift_empty_in <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      wr(a[2:0], rnd());
      rd(a[2:0]);
    end
    receive_active_in <= 1'b1;
    rd(`REG_CTRL_FIRST);
    receive_active_in <= 1'b0;
    // leave a long async period running so the restart lands mid-count
    wr(`REG_TX_CTRL, 8'h00);
    wr(`REG_CTRL_FIRST, 8'h00);
    wr(`REG_DIV_LOW, 8'hc8);
    repeat (500) @(posedge core_clk_in);
    // every sync, wide and high-speed combination
    for (int c = 0; c < 8; c++) begin
      i = c[2:0];
      if (i[2] || (i[1] && i[0])) m = 4;
      else if (i[1] || i[0]) m = 16;
      else m = 64;
      lo = rnd() & 8'h03;
      hi = i[1] ? 8'h01 : (rnd() | 8'h01);
      // software confirms the receiver is idle before it retimes the port
      rd(`REG_CTRL_FIRST);
      n = i[1] ? {hi, lo} : lo;
      p = m * (n + 1);
      wr(`REG_TX_CTRL, {3'b000, i[2], 1'b0, i[0], 2'b00});
      wr(`REG_CTRL_FIRST, {4'h0, i[1], 3'b000});
      wr(`REG_DIV_HIGH, hi);
      wr(`REG_DIV_LOW, lo);
      cmp_byte("sync mode", {7'h00, i[2]}, {7'h00, sync_mode_out});
      per_q.push_back(-p);
      per_q.push_back(p);
      per_q.push_back(p);
      t = n_ticks;
      k = 0;
      while (n_ticks < t + 3 && k < 4 * p + 50) begin
        @(posedge core_clk_in);
        k++;
      end
      if (n_ticks < t + 3) begin
        cmp_int("tick wait", 1, 0);
        break;
      end
      cmp_int("pending periods", 0, per_q.size());
    end
    rd(`REG_TX_CTRL);
    rd(`REG_CTRL_FIRST);
    repeat (4) @(posedge core_clk_in);
    wrap_up();
  end
endmodule : baud_rate_generator_bench

`default_nettype wire
